//--- hdl/intc_pkg.sv
package intc_pkg;

  localparam int          N_SRC               = 5;
  localparam int          ADDR_W              = 8;
  localparam int          STACK_DEPTH         = 128;

  // Source bit positions, also the service order within one priority level
  localparam int          SRC_EXT0            = 0;
  localparam int          SRC_CNT0            = 1;
  localparam int          SRC_EXT1            = 2;
  localparam int          SRC_CNT1            = 3;
  localparam int          SRC_SER             = 4;

  // Entry points in code memory
  localparam logic [15:0] RESET_VECTOR        = 16'h0000;
  localparam logic [15:0] EXT_REQUEST0_VECTOR = 16'h0003;
  localparam logic [15:0] COUNT_UNIT0_VECTOR  = 16'h000B;
  localparam logic [15:0] EXT_REQUEST1_VECTOR = 16'h0013;
  localparam logic [15:0] COUNT_UNIT1_VECTOR  = 16'h001B;
  localparam logic [15:0] SERIAL_VECTOR       = 16'h0023;

  // Values after reset
  localparam logic [4:0]  ENABLE_RESET        = 5'h00;
  localparam logic [4:0]  PRIORITY_RESET      = 5'h00;
  localparam logic [7:0]  STACK_PTR_RESET     = 8'h07;
  localparam logic [2:0]  MASK_RESET          = 3'h0;

  // Register byte addresses
  localparam logic [7:0]  ADDR_ENABLE         = 8'h00;
  localparam logic [7:0]  ADDR_PRIORITY       = 8'h04;
  localparam logic [7:0]  ADDR_STATUS         = 8'h08;
  localparam logic [7:0]  ADDR_MASK           = 8'h0C;
  localparam logic [7:0]  ADDR_STATE          = 8'h10;
  localparam logic [7:0]  ADDR_FETCH          = 8'h14;

  // Status and mask bit positions
  localparam int          STAT_CALL           = 0;
  localparam int          STAT_RET            = 1;
  localparam int          STAT_HELD           = 2;

  localparam logic [1:0]  RESP_OKAY           = 2'h0;
  localparam logic [1:0]  RESP_SLVERR         = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_PUSH_LO = 5'b00010,
    ST_PUSH_HI = 5'b00100,
    ST_POP_HI  = 5'b01000,
    ST_POP_LO  = 5'b10000
  } seq_state_t;

  function automatic logic [15:0] vec_of(input logic [4:0] g);
    logic [15:0] v;
    v = RESET_VECTOR;
    if (g[SRC_EXT0]) v = EXT_REQUEST0_VECTOR;
    else if (g[SRC_CNT0]) v = COUNT_UNIT0_VECTOR;
    else if (g[SRC_EXT1]) v = EXT_REQUEST1_VECTOR;
    else if (g[SRC_CNT1]) v = COUNT_UNIT1_VECTOR;
    else if (g[SRC_SER]) v = SERIAL_VECTOR;
    return v;
  endfunction

endpackage

//--- hdl/prio_pick.sv
`timescale 1ns/10ps
module prio_pick
  import intc_pkg::*;
(
  input  wire logic [N_SRC-1:0] cand,
  output logic      [N_SRC-1:0] grant
);

  logic [N_SRC:0] lower;

  assign lower[0] = 1'b0;

  // Lowest index wins
  genvar i;
  generate
    for (i = 0; i < N_SRC; i++) begin : g_pick
      assign lower[i+1] = lower[i] | cand[i];
      assign grant[i]   = cand[i] & ~lower[i];
    end
  endgenerate

endmodule

//--- hdl/two_level_interrupt_ctrl.sv
`timescale 1ns/10ps
module two_level_interrupt_ctrl
  import intc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              ext_req_pin0,
  input  wire logic              ext_req_pin1,
  input  wire logic              count_unit0_vector_req,
  input  wire logic              count_unit1_vector_req,
  input  wire logic              serial_req,
  input  wire logic              instr_done,
  input  wire logic              return_from_service_instr,
  input  wire logic [15:0]       pc_in,
  input  wire logic              sp_load,
  input  wire logic [7:0]        sp_load_data,
  output logic [15:0]            fetch_counter,
  output logic                   pc_load,
  output logic [N_SRC-1:0]       src_ack,
  output logic                   seq_busy,
  output logic [7:0]             stack_top_pointer,
  output logic [1:0]             in_service,
  output logic                   irq
);

  logic [N_SRC-1:0] en_r, prio_r, src_r, ack_r, req_all, cand_w, grant_w;
  logic [N_SRC-1:0] elig1_w, elig0_w;
  logic [1:0]       ext_s1_r, ext_s2_r, act_r;
  logic [2:0]       stat_r, mask_r, stat_set_w, stat_clr_w;
  logic [7:0]       sp_r, aw_addr_r, rd_addr_w;
  logic [15:0]      fc_r, ret_pc_r;
  logic [7:0]       stack_mem [STACK_DEPTH];
  logic [7:0]       pop_byte_w;
  logic             lvl_r, pc_load_r, irq_r, accept_w, busy_r;
  logic             awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]       bresp_r, rresp_r;
  logic [31:0]      w_data_r, rdata_r, rd_data_w;
  logic             w_strb0_r, wr_fire_w, rd_fire_w, rd_ok_w;
  seq_state_t       st_r;

  // Pin synchronisers for the external request lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_r <= 2'h0;
      ext_s2_r <= 2'h0;
    end else if (ce) begin
      ext_s1_r <= {ext_req_pin1, ext_req_pin0};
      ext_s2_r <= ext_s1_r;
    end
  end

  assign req_all = {serial_req, count_unit1_vector_req, ext_s2_r[1], count_unit0_vector_req, ext_s2_r[0]};

  // Candidate selection by level and blocking
  assign elig1_w = req_all & en_r & prio_r & {N_SRC{~act_r[1]}};
  assign elig0_w = req_all & en_r & ~prio_r & {N_SRC{~act_r[1] & ~act_r[0]}};
  assign cand_w  = (|elig1_w) ? elig1_w : elig0_w;
  assign accept_w = (st_r == ST_IDLE) && instr_done && !return_from_service_instr
                    && (|cand_w);

  prio_pick u_pick (
    .cand  (cand_w),
    .grant (grant_w)
  );

  assign pop_byte_w = stack_mem[sp_r[6:0]];

  // Call and return sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= ST_IDLE;
      sp_r      <= STACK_PTR_RESET;
      fc_r      <= RESET_VECTOR;
      act_r     <= 2'h0;
      src_r     <= '0;
      lvl_r     <= 1'b0;
      ret_pc_r  <= 16'h0000;
      busy_r    <= 1'b0;
      pc_load_r <= 1'b0;
      ack_r     <= '0;
    end else if (ce) begin
      pc_load_r <= 1'b0;
      ack_r     <= '0;
      case (st_r)
        ST_IDLE: begin
          if (return_from_service_instr) begin
            st_r <= ST_POP_HI;
            busy_r <= 1'b1;
          end else if (accept_w) begin
            src_r    <= grant_w;
            lvl_r    <= |(grant_w & prio_r);
            ret_pc_r <= pc_in;
            st_r     <= ST_PUSH_LO;
            busy_r   <= 1'b1;
          end else if (sp_load) begin
            sp_r <= sp_load_data;
          end
        end
        ST_PUSH_LO: begin
          sp_r <= sp_r + 8'h01;
          st_r <= ST_PUSH_HI;
        end
        ST_PUSH_HI: begin
          sp_r       <= sp_r + 8'h01;
          fc_r       <= vec_of(src_r);
          pc_load_r  <= 1'b1;
          ack_r      <= src_r;
          act_r[lvl_r] <= 1'b1;
          busy_r     <= 1'b0;
          st_r       <= ST_IDLE;
        end
        ST_POP_HI: begin
          fc_r[15:8] <= pop_byte_w;
          sp_r       <= sp_r - 8'h01;
          st_r       <= ST_POP_LO;
        end
        ST_POP_LO: begin
          fc_r[7:0] <= pop_byte_w;
          sp_r      <= sp_r - 8'h01;
          pc_load_r <= 1'b1;
          busy_r    <= 1'b0;
          if (act_r[1]) begin
            act_r[1] <= 1'b0;
          end else begin
            act_r[0] <= 1'b0;
          end
          st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // On-chip stack, written at the pre-incremented pointer
  always_ff @(posedge aclk) begin
    if (ce && (st_r == ST_PUSH_LO)) begin
      stack_mem[7'(sp_r + 8'h01)] <= ret_pc_r[7:0];
    end else if (ce && (st_r == ST_PUSH_HI)) begin
      stack_mem[7'(sp_r + 8'h01)] <= ret_pc_r[15:8];
    end
  end

  // Bus write channel
  assign wr_fire_w = !awready_r && !wready_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb0_r <= 1'b0;
    end else if (ce) begin
      if (awready_r && s_axi_awvalid) begin
        aw_addr_r <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (wready_r && s_axi_wvalid) begin
        w_data_r  <= s_axi_wdata;
        w_strb0_r <= s_axi_wstrb[0];
        wready_r  <= 1'b0;
      end
      if (wr_fire_w) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (aw_addr_r == ADDR_ENABLE || aw_addr_r == ADDR_PRIORITY ||
                     aw_addr_r == ADDR_MASK) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Software control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r   <= ENABLE_RESET;
      prio_r <= PRIORITY_RESET;
      mask_r <= MASK_RESET;
    end else if (ce && wr_fire_w && w_strb0_r) begin
      case (aw_addr_r)
        ADDR_ENABLE:   en_r   <= w_data_r[N_SRC-1:0];
        ADDR_PRIORITY: prio_r <= w_data_r[N_SRC-1:0];
        ADDR_MASK:     mask_r <= w_data_r[2:0];
        default:       mask_r <= mask_r;
      endcase
    end
  end

  // Bus read channel
  assign rd_addr_w = s_axi_araddr;
  assign rd_fire_w = arready_r && s_axi_arvalid;

  always_comb begin
    rd_data_w = 32'h0000_0000;
    rd_ok_w   = 1'b1;
    case (rd_addr_w)
      ADDR_ENABLE:   rd_data_w[N_SRC-1:0] = en_r;
      ADDR_PRIORITY: rd_data_w[N_SRC-1:0] = prio_r;
      ADDR_STATUS:   rd_data_w[2:0] = stat_r;
      ADDR_MASK:     rd_data_w[2:0] = mask_r;
      ADDR_STATE:    rd_data_w[15:0] = {1'h0, st_r, act_r, sp_r};
      ADDR_FETCH:    rd_data_w[15:0] = fc_r;
      default:       rd_ok_w = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end else if (ce) begin
      if (rd_fire_w) begin
        rdata_r   <= rd_data_w;
        rresp_r   <= rd_ok_w ? RESP_OKAY : RESP_SLVERR;
        rvalid_r  <= 1'b1;
        arready_r <= 1'b0;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // Sticky status, cleared by read, set wins
  assign stat_set_w[STAT_CALL] = ce && (st_r == ST_PUSH_HI);
  assign stat_set_w[STAT_RET]  = ce && (st_r == ST_POP_LO);
  assign stat_set_w[STAT_HELD] = ce && act_r[1] && (|(req_all & en_r & ~prio_r));
  assign stat_clr_w = (rd_fire_w && rd_addr_w == ADDR_STATUS) ? 3'h7 : 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= 3'h0;
      irq_r  <= 1'b0;
    end else if (ce) begin
      stat_r <= (stat_r & ~stat_clr_w) | stat_set_w;
      irq_r  <= |(((stat_r & ~stat_clr_w) | stat_set_w) & mask_r);
    end
  end

  assign s_axi_awready     = awready_r;
  assign s_axi_wready      = wready_r;
  assign s_axi_bvalid      = bvalid_r;
  assign s_axi_bresp       = bresp_r;
  assign s_axi_arready     = arready_r;
  assign s_axi_rvalid      = rvalid_r;
  assign s_axi_rdata       = rdata_r;
  assign s_axi_rresp       = rresp_r;
  assign fetch_counter     = fc_r;
  assign pc_load           = pc_load_r;
  assign src_ack           = ack_r;
  assign seq_busy          = busy_r;
  assign stack_top_pointer = sp_r;
  assign in_service        = act_r;
  assign irq               = irq_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ENABLE_GATE: assert property (
    ce && st_r == ST_IDLE && !return_from_service_instr && !(|(req_all & en_r))
    |=> st_r != ST_PUSH_LO) else $error("Disabled source started a call");
  AST_WAIT_DONE: assert property (
    ce && st_r == ST_IDLE && !instr_done |=> st_r != ST_PUSH_LO)
    else $error("Call began before instruction completed");
  AST_CALL_VECTOR: assert property (
    ce && st_r == ST_PUSH_HI |=> pc_load_r && fc_r == vec_of(src_r) && ack_r == src_r)
    else $error("Call did not load the source vector");
  AST_RETURN_POP: assert property (
    ce && st_r == ST_IDLE && return_from_service_instr |=> st_r == ST_POP_HI)
    else $error("Return instruction did not start a pop");
  AST_RESET_PC: assert property (
    $rose(aresetn) |-> fc_r == RESET_VECTOR && sp_r == STACK_PTR_RESET && en_r == 5'h00)
    else $error("Reset state wrong");
  AST_NEST: assert property (
    ce && accept_w && act_r == 2'h1 |=> st_r == ST_PUSH_LO ##1 st_r == ST_PUSH_HI [*1])
    else $error("Level 1 request failed to nest");
  AST_HOLD_L1: assert property (
    act_r[1] && ce && st_r == ST_IDLE |=> st_r != ST_PUSH_LO)
    else $error("Request accepted during level 1 service");
  AST_SP_PREINC: assert property (
    ce && st_r == ST_PUSH_LO |=> sp_r == $past(sp_r) + 8'h01)
    else $error("Stack pointer not incremented before push");
  AST_FIXED_ORDER: assert property (
    accept_w |-> (cand_w & (grant_w - 5'h01)) == 5'h00 && $onehot(grant_w))
    else $error("Grant not the first pending source");

  COV_CALL: cover property (ce && st_r == ST_PUSH_HI);
  COV_NESTED: cover property (act_r == 2'h3);
  COV_RETURN: cover property (ce && st_r == ST_POP_LO);
  COV_IRQ: cover property (irq_r);

endmodule

//--- verif/req_sources.sv
`timescale 1ns/10ps
module req_sources (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [4:0] raise,
  input  wire logic [4:0] src_ack,
  output logic            ext_req_pin0,
  output logic            count_unit0_vector_req,
  output logic            ext_req_pin1,
  output logic            count_unit1_vector_req,
  output logic            serial_req
);
  logic [4:0] req_r;

  // Each request is a level held until its acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_r <= 5'h00;
    end else begin
      req_r <= (req_r & ~src_ack) | raise;
    end
  end

  assign ext_req_pin0 = req_r[0];
  assign count_unit0_vector_req   = req_r[1];
  assign ext_req_pin1 = req_r[2];
  assign count_unit1_vector_req   = req_r[3];
  assign serial_req   = req_r[4];
endmodule

//--- verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import intc_pkg::*;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, sp_data = 8'h00, stack_top_pointer;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, pc_load, seq_busy, irq;
  logic [1:0]  bresp, rresp, in_service;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] pc_in = 16'h0, fetch_counter;
  logic [4:0]  raise = 5'h00, src_ack;
  logic        instr_done = 0, ret_pulse = 0, sp_load = 0, ce = 1;
  logic [3:0]  wstrb = 4'hF;
  logic        rq0, rq1, rq2, rq3, rq4;
  int          fails = 0, cmp_count = 0, seed = 64387;

  always #12.5 aclk = ~aclk;

  req_sources src (.aclk(aclk), .aresetn(aresetn), .raise(raise), .src_ack(src_ack),
    .ext_req_pin0(rq0), .count_unit0_vector_req(rq1), .ext_req_pin1(rq2), .count_unit1_vector_req(rq3),
    .serial_req(rq4));

  two_level_interrupt_ctrl dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_req_pin0(rq0), .ext_req_pin1(rq2), .count_unit0_vector_req(rq1), .count_unit1_vector_req(rq3),
    .serial_req(rq4), .instr_done(instr_done), .return_from_service_instr(ret_pulse),
    .pc_in(pc_in), .sp_load(sp_load), .sp_load_data(sp_data),
    .fetch_counter(fetch_counter), .pc_load(pc_load), .src_ack(src_ack),
    .seq_busy(seq_busy), .stack_top_pointer(stack_top_pointer),
    .in_service(in_service), .irq(irq));

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [15:0] exp_vec(input int s);
    case (s)
      0: return 16'h0003;
      1: return 16'h000B;
      2: return 16'h0013;
      3: return 16'h001B;
      default: return 16'h0023;
    endcase
  endfunction

  function automatic int first_src(input logic [4:0] m);
    for (int i = 0; i < 5; i++) if (m[i]) return i;
    return 5;
  endfunction

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!done) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin
        r = bresp;
        bready <= 0;
        done = 1;
      end
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!done) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 0;
        done = 1;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk("write resp", RESP_OKAY, r);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk("read resp", RESP_OKAY, r);
    chk(nm, e, d);
  endtask

  task automatic wait_load(output logic [15:0] fc, output logic [4:0] ak);
    fc = 16'hFFFF;
    ak = 5'h00;
    for (int n = 0; n < 8; n++) begin
      @(posedge aclk);
      if (pc_load === 1'b1) begin
        fc = fetch_counter;
        ak = src_ack;
        n = 8;
      end
    end
  endtask

  task automatic call_once(input logic [4:0] m, input logic [15:0] rp,
                           output logic [15:0] fc, output logic [4:0] ak);
    logic early;
    early = 0;
    @(posedge aclk);
    raise <= m;
    pc_in <= rp;
    @(posedge aclk);
    raise <= 5'h00;
    for (int n = 0; n < 4; n++) begin
      @(posedge aclk);
      early = early | (pc_load !== 1'b0);
    end
    instr_done <= 1;
    @(posedge aclk);
    instr_done <= 0;
    wait_load(fc, ak);
    chk("early load", 0, early);
  endtask

  task automatic ret_once(output logic [15:0] fc);
    logic [4:0] ak;
    @(posedge aclk);
    ret_pulse <= 1;
    @(posedge aclk);
    ret_pulse <= 0;
    @(posedge aclk);
    chk("busy", 1, seq_busy);
    wait_load(fc, ak);
    chk("idle", 0, seq_busy);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    final_report();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] fc, rp, rp2;
    logic [4:0]  ak, m;
    int          s;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd("enable", ADDR_ENABLE, 32'h0);
    rd("priority", ADDR_PRIORITY, 32'h0);
    rd("state", ADDR_STATE, 32'h407);
    rd("fetch", ADDR_FETCH, 32'h0);
    chk("fetch port", 32'h0, fetch_counter);
    axr(8'h18, d, r);
    chk("unmapped resp", RESP_SLVERR, r);
    axw(ADDR_STATUS, 32'h7, r);
    chk("read only resp", RESP_SLVERR, r);
    $display("test reset done");
    @(posedge aclk);
    sp_load <= 1;
    sp_data <= 8'h20;
    @(posedge aclk);
    sp_load <= 0;
    @(posedge aclk);
    chk("sp load", 32'h20, stack_top_pointer);
    ce <= 0;
    sp_load <= 1;
    sp_data <= 8'h55;
    @(posedge aclk);
    sp_load <= 0;
    ce <= 1;
    @(posedge aclk);
    chk("ce freeze", 32'h20, stack_top_pointer);
    wr(ADDR_ENABLE, 32'h1F);
    for (s = 0; s < 5; s++) begin
      rp = 16'($random(seed));
      call_once(5'h01 << s, rp, fc, ak);
      chk("vector", exp_vec(s), fc);
      chk("ack", 5'h01 << s, ak);
      chk("sp push", 32'h22, stack_top_pointer);
      chk("irq masked", 32'h0, irq);
      ret_once(fc);
      chk("return addr", rp, fc);
      chk("sp pop", 32'h20, stack_top_pointer);
    end
    $display("test vectors done");
    for (int k = 0; k < 6; k++) begin
      m = 5'($random(seed));
      if (m == 5'h00) m = 5'h1F;
      rp = 16'($random(seed));
      call_once(m, rp, fc, ak);
      while (m != 5'h00) begin
        s = first_src(m);
        chk("order", exp_vec(s), fc);
        m[s] = 1'b0;
        ret_once(fc);
        chk("return addr", rp, fc);
        if (m != 5'h00) call_once(5'h00, rp, fc, ak);
      end
    end
    $display("test order done");
    wr(ADDR_PRIORITY, 32'h04);
    rd("enable kept", ADDR_ENABLE, 32'h1F);
    wr(ADDR_MASK, 32'h7);
    wstrb <= 4'h0;
    axw(ADDR_MASK, 32'h0, r);
    chk("strb resp", RESP_OKAY, r);
    wstrb <= 4'hF;
    rd("mask kept", ADDR_MASK, 32'h7);
    axr(ADDR_STATUS, d, r);
    rp = 16'($random(seed));
    rp2 = 16'($random(seed));
    call_once(5'h02, rp, fc, ak);
    chk("level0 call", 16'h000B, fc);
    call_once(5'h08, rp2, fc, ak);
    chk("same level held", 16'hFFFF, fc);
    chk("irq set", 32'h1, irq);
    call_once(5'h04, rp2, fc, ak);
    chk("nest", 16'h0013, fc);
    chk("in service", 32'h3, in_service);
    call_once(5'h01, rp, fc, ak);
    chk("held off", 16'hFFFF, fc);
    rd("status", ADDR_STATUS, 32'h5);
    ret_once(fc);
    chk("nest return", rp2, fc);
    chk("level1 cleared", 32'h1, in_service);
    call_once(5'h00, rp2, fc, ak);
    chk("still blocked", 16'hFFFF, fc);
    ret_once(fc);
    chk("outer return", rp, fc);
    call_once(5'h00, rp, fc, ak);
    chk("pending ext0", 16'h0003, fc);
    ret_once(fc);
    call_once(5'h00, rp, fc, ak);
    chk("pending count_unit1_vector", 16'h001B, fc);
    ret_once(fc);
    axr(ADDR_STATUS, d, r);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'h0, irq);
    $display("test nesting done");
    wr(ADDR_ENABLE, 32'h0);
    call_once(5'h1F, rp, fc, ak);
    chk("disabled", 16'hFFFF, fc);
    wr(ADDR_ENABLE, 32'h10);
    call_once(5'h00, rp, fc, ak);
    chk("enabled", 16'h0023, fc);
    $display("test enable done");
    aresetn <= 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd("enable again", ADDR_ENABLE, 32'h0);
    rd("state again", ADDR_STATE, 32'h407);
    chk("fetch again", 32'h0, fetch_counter);
    $display("test reset again done");
    final_report();
  end
endmodule
